// *** rtl/eisp_sense_ctrl.sv ***
// External interrupt sense control register, event status and interrupt output
`timescale 1ns/1ps
//
// Behaviour
// - Sensitivity selection for both groups sits in control bits 4 and 3.
// - One selection applies to port A group and port F group.
// - Selection 00: low level/falling, or high/rising when polarity set.
// - Selection 01: rising only, or falling only when polarity set.
// - Selection 10: falling only, or rising only when polarity set.
// - Selection 11: both edges regardless of polarity.
// - Control bit 2 inverts port A sensitivity when set.
// - Polarity bit changes only when both CPU level bits are 1.
module eisp_sense_ctrl (
  // Clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  // Register port
  input  wire logic [eisp_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [eisp_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [eisp_pkg::DATA_W-1:0]  rdata_o,
  // CPU interrupt level
  input  wire logic                         cpu_level_bit_high_i,
  input  wire logic                         cpu_level_bit_low_i,
  // External pins
  input  wire logic [eisp_pkg::PORT_A_W-1:0] port_a_pins_i,
  input  wire logic [eisp_pkg::PORT_F_W-1:0] port_f_pins_i,
  // Events and interrupt
  output logic                              ext_irq_group_port_a_o,
  output logic                              ext_irq_group_port_f_o,
  output logic                              irq_o
);
  import eisp_pkg::*;

  eisp_sense_t       sense_select_group_a_f;
  logic              port_a_polarity_invert;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   mask;
  logic [EV_W-1:0]   next_status;
  logic [EV_W-1:0]   next_mask;
  logic [EV_W-1:0]   events;
  logic              level3;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              rd_status;
  logic [DATA_W-1:0] next_rdata;

  eisp_det_if a_if ();
  eisp_det_if f_if ();

  // ****************************************************************
  // Decode
  // ****************************************************************
  // CPU level bits come from core logic on this clock, no sync needed
  assign level3    = cpu_level_bit_high_i & cpu_level_bit_low_i;
  assign wr_ctrl   = wr_i && (addr_i == SENSE_CTRL_OFS);
  assign wr_mask   = wr_i && (addr_i == MASK_OFS);
  assign rd_status = rd_i && (addr_i == STATUS_OFS);

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Sensitivity selection is always writable
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sense_select_group_a_f <= EISP_SENSE_LOW_FALL;
    else if (wr_ctrl)
      sense_select_group_a_f <= eisp_sense_t'(wdata_i[SENSE_MSB:SENSE_LSB]);
  end

  // Polarity only moves at CPU level 3, so a lower level task cannot flip it
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      port_a_polarity_invert <= POL_RESET;
    else if (wr_ctrl && level3)
      port_a_polarity_invert <= wdata_i[POL_BIT];
  end

  // ****************************************************************
  // Pin group detectors
  // ****************************************************************
  // Both groups share one selection; only port A sees the inversion
  assign a_if.sense_sel = sense_select_group_a_f;
  assign a_if.invert    = port_a_polarity_invert;
  assign f_if.sense_sel = sense_select_group_a_f;
  assign f_if.invert    = 1'b0;

  eisp_sense_det #(
    .W (PORT_A_W)
  ) u_det_a (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (port_a_pins_i),
    .cfg        (a_if)
  );

  eisp_sense_det #(
    .W (PORT_F_W)
  ) u_det_f (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (port_f_pins_i),
    .cfg        (f_if)
  );

  // ****************************************************************
  // Event status and mask
  // ****************************************************************
  // Read clears the status; a new event in the same cycle wins
  always_comb
  begin
    events              = '0;
    events[EV_A_BIT]    = a_if.trig;
    events[EV_F_BIT]    = f_if.trig;
    next_status         = (rd_status ? EV_RESET : status) | events;
    next_mask           = wr_mask ? wdata_i[EV_W-1:0] : mask;
  end

  // Status flags
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      status <= EV_RESET;
    else
      status <= next_status;
  end

  // Mask register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      mask <= EV_RESET;
    else
      mask <= next_mask;
  end

  // Built from next values so the line tracks status with no extra lag
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(next_status & next_mask);
  end

  // Raw group triggers, one cycle behind the detectors
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_irq_group_port_a_o <= 1'b0;
      ext_irq_group_port_f_o <= 1'b0;
    end
    else
    begin
      ext_irq_group_port_a_o <= a_if.trig;
      ext_irq_group_port_f_o <= f_if.trig;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unused and reserved bits read zero; unmapped addresses read zero
  always_comb
  begin
    next_rdata = REG_RESET;
    if (rd_i)
    begin
      unique case (addr_i)
        SENSE_CTRL_OFS:
        begin
          next_rdata[SENSE_MSB:SENSE_LSB] = sense_select_group_a_f;
          next_rdata[POL_BIT]             = port_a_polarity_invert;
        end
        STATUS_OFS: next_rdata[EV_W-1:0] = status;
        MASK_OFS:   next_rdata[EV_W-1:0] = mask;
        default:    next_rdata = REG_RESET;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= REG_RESET;
    else
      rdata_o <= next_rdata;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence ctrl_write_s;
    wr_ctrl;
  endsequence

  sequence ctrl_read_s;
    rd_i && (addr_i == SENSE_CTRL_OFS);
  endsequence

  sense_store_a: assert property (
    ctrl_write_s |=> sense_select_group_a_f == $past(wdata_i[SENSE_MSB:SENSE_LSB]))
    else $error("sense selection not stored");

  pol_store_a: assert property (
    ctrl_write_s ##0 level3 |=> port_a_polarity_invert == $past(wdata_i[POL_BIT]))
    else $error("polarity write at level 3 lost");

  pol_guard_a: assert property (
    !(wr_ctrl && level3) |=> $stable(port_a_polarity_invert))
    else $error("polarity changed outside a level 3 write");

  shared_sense_a: assert property (
    a_if.sense_sel == f_if.sense_sel)
    else $error("groups see different selections");

  pol_route_a: assert property (
    a_if.invert == port_a_polarity_invert)
    else $error("port A detector misses polarity");

  f_no_invert_a: assert property (
    !f_if.invert)
    else $error("port F group inverted");

  ctrl_readback_a: assert property (
    ctrl_write_s ##1 ctrl_read_s |=>
      rdata_o[SENSE_MSB:SENSE_LSB] == $past(wdata_i[SENSE_MSB:SENSE_LSB], 2))
    else $error("control readback wrong");

  event_sticky_a: assert property (
    a_if.trig |=> status[EV_A_BIT])
    else $error("port A event not latched");

  irq_level_a: assert property (
    ##1 irq_o == |(status & mask))
    else $error("interrupt line disagrees with status");

  read_clear_a: assert property (
    rd_status && !a_if.trig && !f_if.trig |=> status == EV_RESET ##1 !irq_o || status != EV_RESET)
    else $error("status read did not clear");

  // ****************************************************************
  // Register path and status checks
  // ****************************************************************
  sequence status_read_s;
    rd_status;
  endsequence

  f_sticky_a: assert property (
    f_if.trig |=> status[EV_F_BIT])
    else $error("port F event not latched");

  // Only a status read may drop a flag
  status_hold_a: assert property (
    !rd_status |=> (status & $past(status)) == $past(status))
    else $error("status flag lost without a read");

  mask_store_a: assert property (
    wr_mask |=> mask == $past(wdata_i[EV_W-1:0]))
    else $error("mask write not stored");

  status_readback_a: assert property (
    status_read_s |=> rdata_o[EV_W-1:0] == $past(status))
    else $error("status readback wrong");

  // Read data stands one cycle only, zero otherwise
  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == REG_RESET)
    else $error("read data not zero outside a read");

  pol_readback_a: assert property (
    ctrl_read_s |=> rdata_o[POL_BIT] == $past(port_a_polarity_invert))
    else $error("polarity readback wrong");

  grp_out_a: assert property (
    {ext_irq_group_port_f_o, ext_irq_group_port_a_o} == $past({f_if.trig, a_if.trig}))
    else $error("group outputs do not follow detectors");

  pol_low_write_a: assert property (
    ctrl_write_s ##0 !level3 |=> port_a_polarity_invert == $past(port_a_polarity_invert))
    else $error("polarity written below level 3");

  irq_mask_a: assert property (
    mask == EV_RESET && !wr_mask |=> !irq_o)
    else $error("interrupt with all events masked");

  unmapped_read_a: assert property (
    rd_i && addr_i != SENSE_CTRL_OFS && addr_i != STATUS_OFS && addr_i != MASK_OFS
      |=> rdata_o == REG_RESET)
    else $error("unmapped read not zero");

  sel_hold_a: assert property (
    !wr_ctrl |=> $stable(sense_select_group_a_f))
    else $error("selection changed without a write");

endmodule

// *** common/eisp_pkg.sv ***
// Package with constants, types and decode function of the external interrupt sense block
package eisp_pkg;

  // ****************************************************************
  // Register bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] SENSE_CTRL_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h29;
  localparam logic [ADDR_W-1:0] MASK_OFS       = 8'h2A;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned SENSE_MSB  = 4;
  localparam int unsigned SENSE_LSB  = 3;
  localparam int unsigned POL_BIT    = 2;
  localparam int unsigned EV_A_BIT   = 0;
  localparam int unsigned EV_F_BIT   = 1;
  localparam int unsigned EV_W       = 2;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [1:0] EV_RESET     = 2'h0;
  localparam logic       POL_RESET    = 1'h0;

  // ****************************************************************
  // Pin group widths
  // ****************************************************************
  localparam int unsigned PORT_A_W = 4;
  localparam int unsigned PORT_F_W = 3;

  // ****************************************************************
  // Sensitivity selections
  // ****************************************************************
  typedef enum logic [1:0] {
    EISP_SENSE_LOW_FALL = 2'h0,
    EISP_SENSE_RISE     = 2'h1,
    EISP_SENSE_FALL     = 2'h2,
    EISP_SENSE_BOTH     = 2'h3
  } eisp_sense_t;

  // Per pin trigger decode, shared by both pin groups
  function automatic logic eisp_pin_trig(input eisp_sense_t sel, input logic inv,
                                         input logic cur, input logic prv);
    logic rise;
    logic fall;
    logic res;
    rise = cur & ~prv;
    fall = ~cur & prv;
    res  = 1'b0;
    unique case (sel)
      EISP_SENSE_LOW_FALL: res = inv ? cur : ~cur;
      EISP_SENSE_RISE:     res = inv ? fall : rise;
      EISP_SENSE_FALL:     res = inv ? rise : fall;
      EISP_SENSE_BOTH:     res = rise | fall;
    endcase
    return res;
  endfunction

endpackage

// *** common/eisp_det_if.sv ***
// Interface between the sense control and one pin group detector
`timescale 1ns/1ps
interface eisp_det_if;
  import eisp_pkg::*;
  eisp_sense_t sense_sel;
  logic        invert;
  logic        trig;

  modport ctl (output sense_sel, output invert, input trig);
  modport det (input sense_sel, input invert, output trig);
endinterface

// *** rtl/eisp_sense_det.sv ***
// Pin group synchroniser and edge/level trigger detector
`timescale 1ns/1ps
module eisp_sense_det #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Pins
  input  wire logic [W-1:0] pins_i,
  // Configuration and trigger
  eisp_det_if.det           cfg
);
  import eisp_pkg::*;

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] prev;
  logic [W-1:0] next_pin_trig;

  // ****************************************************************
  // Pin synchroniser and history
  // ****************************************************************
  // Two stages, pins are asynchronous to the core clock
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= pins_i;
      sync2 <= sync1;
    end
  end

  // Previous sample for edge detection
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev <= '0;
    else
      prev <= sync2;
  end

  // ****************************************************************
  // Trigger decode
  // ****************************************************************
  // Any pin of the group raises the group trigger
  always_comb
  begin
    next_pin_trig = '0;
    for (int i = 0; i < W; i++)
      next_pin_trig[i] = eisp_pin_trig(cfg.sense_sel, cfg.invert, sync2[i], prev[i]);
  end

  // Registered group trigger
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg.trig <= 1'b0;
    else
      cfg.trig <= |next_pin_trig;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence rise_s;
    |(sync2 & ~prev);
  endsequence

  sequence fall_s;
    |(~sync2 & prev);
  endsequence

  low_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg.sense_sel == EISP_SENSE_LOW_FALL) && !cfg.invert && |(~sync2) |=> cfg.trig)
    else $error("low level did not trigger");
  rise_only_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg.sense_sel == EISP_SENSE_RISE) && !cfg.invert && (sync2 == prev) |=> !cfg.trig)
    else $error("rising mode triggered without edge");
  fall_inv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg.sense_sel == EISP_SENSE_FALL) && cfg.invert ##0 rise_s |=> cfg.trig)
    else $error("inverted falling mode missed rising edge");
  both_edges_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg.sense_sel == EISP_SENSE_BOTH) ##0 (rise_s or fall_s) |=> cfg.trig)
    else $error("both edge mode missed an edge");

endmodule

// *** testbench/eisp_pin_src.sv ***
// Behavioural source for the external port A and port F pins
`timescale 1ns/1ps
module eisp_pin_src #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Longest hold of one pin pattern, in cycles, less one
  input  wire logic [3:0]   hold_max_i,
  // Pins
  output logic      [W-1:0] pins_o
);
  int unsigned hold;

  // New random pattern after a random hold; zero hold gives a new random pattern every cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pins_o <= '0;
      hold   <= 0;
    end
    else if (hold == 0)
    begin
      pins_o <= W'($urandom);
      hold   <= $urandom_range(hold_max_i, 0);
    end
    else
      hold <= hold - 1;
  end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench of the external interrupt sense block
`timescale 1ns/1ps
module tb_top;
  import eisp_pkg::*;
  logic       core_clk_i, rst_i, wr_i, rd_i, lvl_hi, lvl_lo, ga, gf, irq_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [3:0] pa, hold_max, a1, a2, ap;
  logic [2:0] pf, f1, f2, fp;
  logic [1:0] m_sel, m_stat, m_mask, m_trig, m_grp, lv;
  logic       m_pol, m_irq;
  logic [7:0] m_rdata;
  int         error_cnt;
  int         check_count;

  // ****************************************************************
  // Design and pin sources
  // ****************************************************************
  eisp_sense_ctrl i_eisp_sense_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cpu_level_bit_high_i(lvl_hi), .cpu_level_bit_low_i(lvl_lo), .port_a_pins_i(pa),
    .port_f_pins_i(pf), .ext_irq_group_port_a_o(ga), .ext_irq_group_port_f_o(gf), .irq_o(irq_o));
  eisp_pin_src #(.W(4)) i_eisp_pin_src (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .hold_max_i(hold_max), .pins_o(pa));
  eisp_pin_src #(.W(3)) i_eisp_pin_src_f (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .hold_max_i(hold_max), .pins_o(pf));

  // ****************************************************************
  // Reference model
  // ****************************************************************
  // Trigger of one group, written straight from the sensitivity table
  function automatic logic grp(input logic [1:0] s, input logic inv, input logic [3:0] c,
                               input logic [3:0] p, input int n);
    logic t;
    t = 1'b0;
    for (int k = 0; k < n; k++)
      case (s)
        2'h0: t |= inv ? c[k] : !c[k];
        2'h1: t |= inv ? (p[k] && !c[k]) : (c[k] && !p[k]);
        2'h2: t |= inv ? (c[k] && !p[k]) : (p[k] && !c[k]);
        default: t |= c[k] ^ p[k];
      endcase
    return t;
  endfunction

  // Pipeline of two sync stages, trigger stage, then outputs and status
  always @(posedge core_clk_i or posedge rst_i)
  begin : mdl
    logic [1:0] ns;
    if (rst_i)
      {a1, a2, ap, f1, f2, fp, m_sel, m_pol, m_stat, m_mask, m_trig, m_grp} <= '0;
    if (rst_i)
      {m_irq, m_rdata} <= '0;
    else
    begin
      a1 <= pa; a2 <= a1; ap <= a2; f1 <= pf; f2 <= f1; fp <= f2;
      m_trig <= {grp(m_sel, 1'b0, {1'b0, f2}, {1'b0, fp}, 3), grp(m_sel, m_pol, a2, ap, 4)};
      m_grp <= m_trig;
      // Read clear loses against a new event
      ns = ((rd_i && addr_i == STATUS_OFS) ? 2'b00 : m_stat) | m_trig;
      m_stat <= ns;
      // Line follows the mask that stands after this edge
      m_irq <= |(ns & ((wr_i && addr_i == MASK_OFS) ? wdata_i[1:0] : m_mask));
      if (wr_i && addr_i == SENSE_CTRL_OFS)
      begin
        m_sel <= wdata_i[4:3];
        if (lvl_hi && lvl_lo) m_pol <= wdata_i[2];
      end
      if (wr_i && addr_i == MASK_OFS) m_mask <= wdata_i[1:0];
      m_rdata <= !rd_i ? 8'h00 : addr_i == SENSE_CTRL_OFS ? {3'h0, m_sel, m_pol, 2'h0} :
                 addr_i == STATUS_OFS ? {6'h00, m_stat} :
                 addr_i == MASK_OFS ? {6'h00, m_mask} : 8'h00;
    end
  end

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Outputs compared at the falling edge, where they are settled
  always @(negedge core_clk_i)
  begin
    check(rdata_o, m_rdata);
    check({7'h00, ga}, {7'h00, m_grp[0]});
    check({7'h00, gf}, {7'h00, m_grp[1]});
    // Level interrupt from unmasked status of both groups
    check({7'h00, irq_o}, {7'h00, m_irq});
  end

  task automatic finish_test;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One bus cycle; strobes stay up so cycles may follow back to back
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    {lvl_hi, lvl_lo} <= lv;
    @(posedge core_clk_i);
  endtask

  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    finish_test;
  end

  initial
  begin
    {wr_i, rd_i, lvl_hi, lvl_lo} = '0;
    {addr_i, wdata_i} = '0;
    hold_max = 4'h0;
    lv = 2'h0;
    rst_i = 1'b1;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(32'hFBC6));
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    idle(8);
    // Every selection with both polarities, level 3 and below, fast and slow pins
    for (int i = 0; i < 32; i++)
    begin
      lv = i[3] ? 2'h3 : 2'($urandom_range(2, 0));
      hold_max <= i[4] ? 4'hF : 4'h0;
      bus(1'b1, SENSE_CTRL_OFS, {3'($urandom), i[1:0], i[2], 2'($urandom)});
      bus(1'b0, SENSE_CTRL_OFS, 8'h00);
      bus(1'b1, MASK_OFS, 8'($urandom));
      idle(20);
      bus(1'b0, SENSE_CTRL_OFS, 8'h00);
      bus(1'b0, STATUS_OFS, 8'h00);
      bus(1'b0, STATUS_OFS, 8'h00);
      bus(1'b0, MASK_OFS, 8'h00);
      idle(1);
    end
    // Unmapped place and read-only status
    bus(1'b1, 8'h2B, 8'hFF);
    bus(1'b1, STATUS_OFS, 8'hFF);
    bus(1'b0, 8'h2B, 8'h00);
    bus(1'b0, 8'h00, 8'h00);
    idle(2);
    // Second reset in mid-run, then registers back at their reset values
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(10);
    bus(1'b0, SENSE_CTRL_OFS, 8'h00);
    bus(1'b0, MASK_OFS, 8'h00);
    idle(3);
    finish_test;
  end
endmodule
